// File: verilog/isw_irq_ctrl.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Only clockless sources wake from sleep
// - Wake vectors if global enable, else continues
// - Post-sleep instruction runs before any vectoring
// - External pin interrupt is edge triggered
// - Edge select: set rising, clear falling
// - Valid pin edge sets external pin flag
// - Flag with both enables redirects to vector
// - Clearing pin enable blocks pin interrupt
// - Only return PC is pushed
// - Vector address is fixed at 0004h
// - Upper PC latch is never touched
// - Control register bit layout, bit 7 down
// - Global enable gates every interrupt
// - Peripheral enable gates peripheral sources
// - Timer flag sticks until software clears
// - Accept: flush, clear global, push, load
// - Flags set regardless of any enables
// - Return instruction pops PC, sets global enable
// - Synchronous event to vector in three cycles
module isw_irq_ctrl #(
  parameter int ADDR_W = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [isw_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [isw_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic ext_pin_i,
  input wire logic timer_overflow_i,
  input wire logic port_change_i,
  input wire logic periph_irq_i,
  input wire logic periph_wake_i,
  input wire logic sleep_i,
  input wire logic return_from_irq_instr_i,
  input wire logic [isw_pkg::PC_W-1:0] pc_i,
  output isw_pkg::isw_vec_s vec_o,
  output logic wake_o
);
  logic global_irq_enable_q;
  logic peripheral_irq_enable_q;
  logic timer_overflow_irq_enable_q;
  logic ext_pin_irq_enable_q;
  logic port_change_irq_enable_q;
  logic timer_overflow_flag_q;
  logic ext_pin_irq_flag_q;
  logic port_change_flag_q;
  logic ext_edge_select_q;
  logic [isw_pkg::DATA_W-1:0] rdata_q;
  logic [isw_pkg::DATA_W-1:0] ctrl_view;
  logic [isw_pkg::DATA_W-1:0] stat_view;
  logic ctrl_wr;
  logic edge_wr;
  logic ext_edge;
  logic pending;
  logic wake_req;
  logic busy;

  initial begin
    if (ADDR_W < 2) begin
      $error("isw_irq_ctrl needs ADDR_W of at least 2");
    end
  end

  assign ctrl_wr = reg_wr_i && (reg_addr_i == ADDR_W'(isw_pkg::CTRL_OFS));
  assign edge_wr = reg_wr_i && (reg_addr_i == ADDR_W'(isw_pkg::EDGE_OFS));

  isw_pin_edge #(
    .STAGES(isw_pkg::SYNC_STAGES)
  ) u_pin_edge (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_pin_i),
    .rise_sel_i(ext_edge_select_q),
    .edge_o(ext_edge)
  );

  // Enables: plain software bits, reset clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peripheral_irq_enable_q <= isw_pkg::CTRL_RESET[isw_pkg::PER_EN_BIT];
      timer_overflow_irq_enable_q <= isw_pkg::CTRL_RESET[isw_pkg::TMR_EN_BIT];
      ext_pin_irq_enable_q <= isw_pkg::CTRL_RESET[isw_pkg::PIN_EN_BIT];
      port_change_irq_enable_q <= isw_pkg::CTRL_RESET[isw_pkg::PORT_EN_BIT];
    end else if (ctrl_wr) begin
      peripheral_irq_enable_q <= reg_wdata_i[isw_pkg::PER_EN_BIT];
      timer_overflow_irq_enable_q <= reg_wdata_i[isw_pkg::TMR_EN_BIT];
      ext_pin_irq_enable_q <= reg_wdata_i[isw_pkg::PIN_EN_BIT];
      port_change_irq_enable_q <= reg_wdata_i[isw_pkg::PORT_EN_BIT];
    end
  end

  // Hardware clear on accept beats set; set by return beats software
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable_q <= isw_pkg::CTRL_RESET[isw_pkg::GLB_EN_BIT];
    end else if (vec_o.flush) begin
      global_irq_enable_q <= 1'b0;
    end else if (return_from_irq_instr_i) begin
      global_irq_enable_q <= 1'b1;
    end else if (ctrl_wr) begin
      global_irq_enable_q <= reg_wdata_i[isw_pkg::GLB_EN_BIT];
    end
  end

  // Flags: event wins over a software clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_overflow_flag_q <= isw_pkg::CTRL_RESET[isw_pkg::TMR_FLAG_BIT];
    end else if (timer_overflow_i) begin
      timer_overflow_flag_q <= 1'b1;
    end else if (ctrl_wr) begin
      timer_overflow_flag_q <= reg_wdata_i[isw_pkg::TMR_FLAG_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_pin_irq_flag_q <= isw_pkg::CTRL_RESET[isw_pkg::PIN_FLAG_BIT];
    end else if (ext_edge) begin
      ext_pin_irq_flag_q <= 1'b1;
    end else if (ctrl_wr) begin
      ext_pin_irq_flag_q <= reg_wdata_i[isw_pkg::PIN_FLAG_BIT];
    end
  end

  // Left without reset: its value after reset is undefined
  always_ff @(posedge clock_i) begin
    if (port_change_i) begin
      port_change_flag_q <= 1'b1;
    end else if (ctrl_wr) begin
      port_change_flag_q <= reg_wdata_i[isw_pkg::PORT_FLAG_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_edge_select_q <= isw_pkg::EDGE_SEL_RESET;
    end else if (edge_wr) begin
      ext_edge_select_q <= reg_wdata_i[isw_pkg::EDGE_SEL_BIT];
    end
  end

  // Per-source masks, then peripheral gate, then global gate
  assign pending = global_irq_enable_q & (
      (ext_pin_irq_enable_q & ext_pin_irq_flag_q) |
      (timer_overflow_irq_enable_q & timer_overflow_flag_q) |
      (port_change_irq_enable_q & port_change_flag_q) |
      (peripheral_irq_enable_q & periph_irq_i));

  // Timer stops in sleep, so it cannot wake; global enable not needed
  assign wake_req = (ext_pin_irq_enable_q & ext_pin_irq_flag_q) |
      (port_change_irq_enable_q & port_change_flag_q) |
      (peripheral_irq_enable_q & periph_wake_i);

  // Only the PC path is driven; upper PC latch has no port here
  isw_vec_seq u_vec_seq (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pending_i(pending),
    .wake_req_i(wake_req),
    .sleep_i(sleep_i),
    .pc_i(pc_i),
    .vec_o(vec_o),
    .wake_o(wake_o),
    .busy_o(busy)
  );

  always_comb begin
    ctrl_view = '0;
    ctrl_view[isw_pkg::GLB_EN_BIT] = global_irq_enable_q;
    ctrl_view[isw_pkg::PER_EN_BIT] = peripheral_irq_enable_q;
    ctrl_view[isw_pkg::TMR_EN_BIT] = timer_overflow_irq_enable_q;
    ctrl_view[isw_pkg::PIN_EN_BIT] = ext_pin_irq_enable_q;
    ctrl_view[isw_pkg::PORT_EN_BIT] = port_change_irq_enable_q;
    ctrl_view[isw_pkg::TMR_FLAG_BIT] = timer_overflow_flag_q;
    ctrl_view[isw_pkg::PIN_FLAG_BIT] = ext_pin_irq_flag_q;
    ctrl_view[isw_pkg::PORT_FLAG_BIT] = port_change_flag_q;
  end

  always_comb begin
    stat_view = '0;
    stat_view[isw_pkg::STAT_BUSY_BIT] = busy;
    stat_view[isw_pkg::STAT_SLEEP_BIT] = sleep_i;
    stat_view[isw_pkg::STAT_WAKE_BIT] = wake_req;
  end

  // Unmapped reads return zero
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (!reg_rd_i) begin
      rdata_q <= '0;
    end else if (reg_addr_i == ADDR_W'(isw_pkg::CTRL_OFS)) begin
      rdata_q <= ctrl_view;
    end else if (reg_addr_i == ADDR_W'(isw_pkg::EDGE_OFS)) begin
      rdata_q <= {{(isw_pkg::DATA_W-1){1'b0}}, ext_edge_select_q};
    end else if (reg_addr_i == ADDR_W'(isw_pkg::STAT_OFS)) begin
      rdata_q <= stat_view;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;

  ext_flag_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ext_edge |=> ext_pin_irq_flag_q)
    else $error("pin edge did not set flag");
  flag_any_enable_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    (timer_overflow_i && !timer_overflow_irq_enable_q &&
     !global_irq_enable_q) |=> timer_overflow_flag_q)
    else $error("flag not set with enables clear");
  timer_flag_hold_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    (timer_overflow_flag_q && !ctrl_wr) |=> timer_overflow_flag_q)
    else $error("timer flag cleared by hardware");
  accept_order_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    vec_o.flush |=> (vec_o.push && !global_irq_enable_q &&
                     vec_o.pc == $past(pc_i)) ##1 vec_o.load)
    else $error("accept sequence out of order");
  vector_addr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    vec_o.load |-> vec_o.pc == isw_pkg::VECTOR_PC)
    else $error("vector address wrong");
  global_block_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !global_irq_enable_q |-> !vec_o.flush)
    else $error("vectoring with global enable clear");
  pin_vector_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (global_irq_enable_q && ext_pin_irq_enable_q && ext_pin_irq_flag_q &&
     !busy && !sleep_i) |-> vec_o.flush)
    else $error("enabled pin flag not taken");
  pin_disable_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (vec_o.flush && !ext_pin_irq_enable_q) |->
      (timer_overflow_irq_enable_q || port_change_irq_enable_q ||
       peripheral_irq_enable_q))
    else $error("pin taken with its enable clear");
  periph_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (vec_o.flush && !peripheral_irq_enable_q) |->
      (ext_pin_irq_enable_q || timer_overflow_irq_enable_q ||
       port_change_irq_enable_q))
    else $error("peripheral taken with gate clear");
  return_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (return_from_irq_instr_i && !vec_o.flush) |=>
      global_irq_enable_q)
    else $error("return did not restore global enable");
  timer_latency_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    (timer_overflow_i && global_irq_enable_q && timer_overflow_irq_enable_q
     && !busy && !sleep_i && !pending) ##1 (!busy && !sleep_i)
    |=> ##1 vec_o.load)
    else $error("synchronous latency not three cycles");
  wake_source_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (sleep_i && timer_overflow_flag_q && timer_overflow_irq_enable_q &&
     !(ext_pin_irq_enable_q && ext_pin_irq_flag_q) &&
     !(port_change_irq_enable_q && port_change_flag_q) &&
     !(peripheral_irq_enable_q && periph_wake_i)) |-> !wake_o)
    else $error("wake from a clocked source");
  wake_step_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wake_o |=> !vec_o.flush)
    else $error("vectored before post-sleep step");
endmodule : isw_irq_ctrl

// File: pkg/isw_pkg.sv
package isw_pkg;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam logic [PC_W-1:0] VECTOR_PC = 13'h0004;
  // Register indices on the plain register port
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] EDGE_OFS = 4'h1;
  localparam logic [3:0] STAT_OFS = 4'h2;
  // Control, edge select and status register bit positions
  localparam int GLB_EN_BIT = 7;
  localparam int PER_EN_BIT = 6;
  localparam int TMR_EN_BIT = 5;
  localparam int PIN_EN_BIT = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int TMR_FLAG_BIT = 2;
  localparam int PIN_FLAG_BIT = 1;
  localparam int PORT_FLAG_BIT = 0;
  localparam int EDGE_SEL_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_WAKE_BIT = 2;
  // Full width so bit 7 has a defined reset value
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic EDGE_SEL_RESET = 1'b1;
  localparam int SYNC_STAGES = 2;
  localparam int LATENCY_SYNC = 3;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PUSH,
    SEQ_LOAD,
    SEQ_WAKE_STEP
  } isw_seq_e;

  typedef struct packed {
    logic flush;
    logic push;
    logic load;
    logic [PC_W-1:0] pc;
  } isw_vec_s;
endpackage : isw_pkg

// File: verilog/isw_pin_edge.sv
`timescale 1ns/1ps
module isw_pin_edge #(
  parameter int STAGES = isw_pkg::SYNC_STAGES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic rise_sel_i,
  output logic edge_o
);
  logic [STAGES-1:0] sync_q;
  logic prev_q;

  initial begin
    if (STAGES < 2) begin
      $error("isw_pin_edge needs at least two stages");
    end
  end

  // Pin is asynchronous; only the last stage feeds logic
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], pin_i};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync_q[STAGES-1];
    end
  end

  // Edge, not level: one pulse per transition of the selected polarity
  assign edge_o = rise_sel_i ? (sync_q[STAGES-1] & ~prev_q)
                             : (~sync_q[STAGES-1] & prev_q);

  rise_edge_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rise_sel_i && sync_q[STAGES-1] && !prev_q) |-> edge_o)
    else $error("rising edge missed");
  fall_edge_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!rise_sel_i && !sync_q[STAGES-1] && prev_q) |-> edge_o)
    else $error("falling edge missed");
  level_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (sync_q[STAGES-1] == prev_q) |-> !edge_o)
    else $error("edge pulse on a steady level");
endmodule : isw_pin_edge

// File: verilog/isw_vec_seq.sv
`timescale 1ns/1ps
module isw_vec_seq (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pending_i,
  input wire logic wake_req_i,
  input wire logic sleep_i,
  input wire logic [isw_pkg::PC_W-1:0] pc_i,
  output isw_pkg::isw_vec_s vec_o,
  output logic wake_o,
  output logic busy_o
);
  isw_pkg::isw_seq_e state_q;
  isw_pkg::isw_seq_e state_d;
  logic [isw_pkg::PC_W-1:0] pc_q;
  logic flush;

  // No vectoring while asleep or during the post-sleep step
  assign wake_o = (state_q == isw_pkg::SEQ_IDLE) & sleep_i & wake_req_i;
  assign flush = (state_q == isw_pkg::SEQ_IDLE) & ~sleep_i & pending_i;
  assign busy_o = (state_q != isw_pkg::SEQ_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      isw_pkg::SEQ_IDLE: begin
        if (wake_o) begin
          state_d = isw_pkg::SEQ_WAKE_STEP;
        end else if (flush) begin
          state_d = isw_pkg::SEQ_PUSH;
        end
      end
      isw_pkg::SEQ_PUSH: state_d = isw_pkg::SEQ_LOAD;
      isw_pkg::SEQ_LOAD: state_d = isw_pkg::SEQ_IDLE;
      isw_pkg::SEQ_WAKE_STEP: state_d = isw_pkg::SEQ_IDLE;
      default: state_d = isw_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= isw_pkg::SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Return PC shown with push, fixed vector shown with load
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q <= '0;
    end else if (flush) begin
      pc_q <= pc_i;
    end else if (state_q == isw_pkg::SEQ_PUSH) begin
      pc_q <= isw_pkg::VECTOR_PC;
    end
  end

  assign vec_o.flush = flush;
  assign vec_o.push = (state_q == isw_pkg::SEQ_PUSH);
  assign vec_o.load = (state_q == isw_pkg::SEQ_LOAD);
  assign vec_o.pc = pc_q;
endmodule : isw_vec_seq

// File: test/isw_core_model.sv
`timescale 1ns/1ps
module isw_core_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire isw_pkg::isw_vec_s vec_i,
  input wire logic wake_i,
  input wire logic sleep_req_i,
  input wire logic ret_i,
  output logic [isw_pkg::PC_W-1:0] pc_o,
  output logic sleep_o
);
  logic [isw_pkg::PC_W-1:0] pc_q;
  logic [isw_pkg::PC_W-1:0] stack_q;
  logic sleep_q;
  assign pc_o = pc_q;
  assign sleep_o = sleep_q;
  // Fetch runs free so every vector pushes a fresh return address
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q <= 13'h0100;
    end else if (vec_i.load) begin
      pc_q <= vec_i.pc;
    end else if (ret_i) begin
      pc_q <= stack_q;
    end else if (!sleep_q) begin
      pc_q <= pc_q + 13'h0001;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) stack_q <= 13'h0000;
    else if (vec_i.push) stack_q <= vec_i.pc;
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) sleep_q <= 1'b0;
    else if (wake_i) sleep_q <= 1'b0;
    else if (sleep_req_i) sleep_q <= 1'b1;
  end
endmodule : isw_core_model

// File: test/test_irq_sleep_wake_ext_pin.sv
`timescale 1ns/1ps
module test_irq_sleep_wake_ext_pin;
  logic clock_i = 0;
  logic rst_n_i = 0;
  logic [3:0] addr = '0;
  logic [7:0] wd = '0;
  logic wr = 0, rd = 0, pin = 0, tov = 0, pch = 0;
  logic pirq = 0, pwake = 0, ret = 0, sreq = 0, slp, wake;
  logic [7:0] rdat;
  logic [12:0] pc;
  isw_pkg::isw_vec_s vec;
  int n_errors = 0, checks = 0, cyc = 0, n_fl = 0, n_wk = 0, k;
  isw_irq_ctrl u_isw_irq_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .ext_pin_i(pin), .timer_overflow_i(tov),
    .port_change_i(pch), .periph_irq_i(pirq), .periph_wake_i(pwake),
    .sleep_i(slp), .return_from_irq_instr_i(ret), .pc_i(pc),
    .vec_o(vec), .wake_o(wake));
  isw_core_model u_isw_core_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .vec_i(vec), .wake_i(wake), .sleep_req_i(sreq), .ret_i(ret),
    .pc_o(pc), .sleep_o(slp));
  initial forever #4 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    n_fl += (vec.flush === 1'b1);
    n_wk += (wake === 1'b1);
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic wreg(logic [3:0] a, logic [7:0] d);
    @(posedge clock_i);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clock_i);
    wr <= 0;
  endtask : wreg
  task automatic chk(logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clock_i);
    rd <= 1;
    addr <= a;
    @(posedge clock_i);
    rd <= 0;
    @(negedge clock_i);
    cmp("reg", {8'h00, e}, {8'h00, rdat & m});
  endtask : chk
  task automatic pulse(int w);
    @(posedge clock_i);
    case (w)
      0: tov <= 1;
      1: pch <= 1;
      2: ret <= 1;
      default: sreq <= 1;
    endcase
    @(posedge clock_i);
    {tov, pch, ret, sreq} <= 4'h0;
  endtask : pulse
  task automatic flip();
    @(posedge clock_i);
    pin <= ~pin;
    @(posedge clock_i);
  endtask : flip
  task automatic vchk(output int n);
    logic [12:0] p;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (vec.flush !== 1'b1 && n < 20);
    p = pc;
    @(negedge clock_i);
    cmp("push", {2'b00, vec.push, vec.pc}, {3'b001, p});
    @(negedge clock_i);
    cmp("load", {2'b00, vec.load, vec.pc},
      {3'b001, isw_pkg::VECTOR_PC});
  endtask : vchk
  task automatic wchk(logic gv);
    int i;
    i = 0;
    do begin
      @(negedge clock_i);
      i++;
    end while (wake !== 1'b1 && i < 20);
    cmp("wake", 16'h0001, {15'h0, wake});
    @(negedge clock_i);
    cmp("step", 16'h0000, {15'h0, vec.flush});
    @(negedge clock_i);
    cmp("resume", {15'h0, gv}, {15'h0, vec.flush});
  endtask : wchk
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1;
    chk(isw_pkg::CTRL_OFS, 8'hfe, 8'h00);
    chk(isw_pkg::EDGE_OFS, 8'hff, 8'h01);
    chk(isw_pkg::STAT_OFS, 8'hff, 8'h00);
    wreg(isw_pkg::CTRL_OFS, 8'h79);
    wreg(4'h5, 8'hff);
    chk(4'h5, 8'hff, 8'h00);
    chk(isw_pkg::CTRL_OFS, 8'hff, 8'h79);
    wreg(isw_pkg::CTRL_OFS, 8'h00);
    pulse(0);
    pulse(1);
    repeat (20) @(posedge clock_i);
    chk(isw_pkg::CTRL_OFS, 8'hff, 8'h05);
    // Level held between clears proves edge, not level, sensing
    for (int s = 1; s >= 0; s--) begin
      wreg(isw_pkg::EDGE_OFS, {7'h00, s[0]});
      repeat (4) begin
        wreg(isw_pkg::CTRL_OFS, 8'h00);
        flip();
        repeat (6) @(posedge clock_i);
        chk(isw_pkg::CTRL_OFS, 8'hff,
          {6'h00, pin == s[0], 1'b0});
      end
    end
    wreg(isw_pkg::CTRL_OFS, 8'ha0);
    pulse(0);
    vchk(k);
    cmp("lat", 16'(k + 2), 16'(isw_pkg::LATENCY_SYNC));
    repeat (10) @(posedge clock_i);
    chk(isw_pkg::CTRL_OFS, 8'hff, 8'h24);
    wreg(isw_pkg::CTRL_OFS, 8'h20);
    pulse(2);
    chk(isw_pkg::CTRL_OFS, 8'hff, 8'ha0);
    wreg(isw_pkg::EDGE_OFS, 8'h01);
    wreg(isw_pkg::CTRL_OFS, 8'h90);
    flip();
    vchk(k);
    cmp("pin lat", 16'(k + 2), 16'd5);
    wreg(isw_pkg::EDGE_OFS, 8'h00);
    wreg(isw_pkg::CTRL_OFS, 8'h80);
    k = n_fl;
    flip();
    repeat (10) @(posedge clock_i);
    chk(isw_pkg::CTRL_OFS, 8'hff, 8'h82);
    wreg(isw_pkg::CTRL_OFS, 8'h7f);
    @(posedge clock_i) pirq <= 1;
    repeat (10) @(posedge clock_i);
    cmp("no vec", 16'(k), 16'(n_fl));
    wreg(isw_pkg::CTRL_OFS, 8'h80);
    repeat (10) @(posedge clock_i);
    cmp("no vec", 16'(k), 16'(n_fl));
    wreg(isw_pkg::CTRL_OFS, 8'hc0);
    vchk(k);
    @(posedge clock_i) pirq <= 0;
    wreg(isw_pkg::CTRL_OFS, 8'h20);
    pulse(3);
    k = n_wk;
    pulse(0);
    repeat (10) @(posedge clock_i);
    cmp("no wake", 16'(k), 16'(n_wk));
    wreg(isw_pkg::EDGE_OFS, 8'h01);
    wreg(isw_pkg::CTRL_OFS, 8'h90);
    flip();
    wchk(1'b1);
    repeat (6) @(posedge clock_i);
    wreg(isw_pkg::CTRL_OFS, 8'h40);
    pulse(3);
    @(posedge clock_i) pwake <= 1;
    wchk(1'b0);
    @(posedge clock_i) pwake <= 0;
    end_sim();
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
endmodule : test_irq_sleep_wake_ext_pin
